/* logic/dcsc_regs.svh */
// Summary of operation
// - request arises from software request bit or selected peripheral interrupt line.
// - a channel whose parameter register is all zero refuses new requests.
// - mode codes disabled, single, repeat; mode written last during setup.
// - an accepted transfer finishes even if mode is cleared meanwhile.
`ifndef DCSC_REGS_SVH
`define DCSC_REGS_SVH
`define DCSC_OFS_MODE0     8'h00
`define DCSC_OFS_SEL0      8'h04
`define DCSC_OFS_SEL20     8'h08
`define DCSC_OFS_PARAM0    8'h0C
`define DCSC_CH_STRIDE     8'h10
`define DCSC_OFS_STATUS    8'h40
`define DCSC_OFS_DONE      8'h44
`define DCSC_MODE_LSB      0
`define DCSC_WIDTH_LSB     2
`define DCSC_SADIR_BIT     4
`define DCSC_DADIR_BIT     5
`define DCSC_SWREQ_BIT     0
`define DCSC_SEL_LSB       0
`define DCSC_SEL_W         5
`define DCSC_MODE_RST      8'h00
`define DCSC_SEL_RST       8'h00
`define DCSC_PARAM_RST     24'h000000
`define DCSC_SETTLE_CYC    6
`endif

/* logic/dcsc_pkg.sv */
package dcsc_pkg;
	typedef enum logic [1:0] {
		DCSC_MODE_OFF    = 2'b00,
		DCSC_MODE_SINGLE = 2'b01,
		DCSC_MODE_RSVD   = 2'b10,
		DCSC_MODE_REPEAT = 2'b11
	} dcsc_mode_t;
	typedef enum logic [1:0] {
		DCSC_ST_IDLE = 2'b00,
		DCSC_ST_BUSY = 2'b01
	} dcsc_state_t;
endpackage

/* logic/dcsc_sync.sv */
`timescale 1ns/1ps
// three-stage input synchroniser with agreement filter
module dcsc_sync #(
	parameter int W = 32
) (
	input  wire logic         core_clk,
	input  wire logic         arst_n,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	wire  [W-1:0] agree = ~(s2 ^ s3);
	wire  [W-1:0] next_out = (agree & s2) | (~agree & sync_out);
	// stage registers, output follows once stages two and three agree
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1       <= '0;
			s2       <= '0;
			s3       <= '0;
			sync_out <= '0;
		end else if (clk_en) begin
			s1       <= async_in;
			s2       <= s1;
			s3       <= s2;
			sync_out <= next_out;
		end
	end
endmodule // dcsc_sync

/* logic/dcsc_chan.sv */
`timescale 1ns/1ps
`include "dcsc_regs.svh"
// per-channel request acceptance and transfer tracking
module dcsc_chan (
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic       clk_en,
	input  wire logic [1:0] mode,
	input  wire logic       param_zero,
	input  wire logic       sw_req,
	input  wire logic       periph_req,
	input  wire logic       xfer_done,
	output logic            xfer_req,
	output logic            busy,
	output logic            pending
);
	dcsc_pkg::dcsc_state_t state;
	dcsc_pkg::dcsc_state_t next_state;
	logic                  periph_q;
	wire mode_on   = (mode == dcsc_pkg::DCSC_MODE_SINGLE) || (mode == dcsc_pkg::DCSC_MODE_REPEAT);
	wire periph_rise = periph_req & ~periph_q;
	wire raw_req   = sw_req | periph_rise;
	wire can_take  = mode_on & ~param_zero;
	// a held request is dropped, not taken, once mode or parameter turn it away
	wire take      = (state == dcsc_pkg::DCSC_ST_IDLE) & can_take & (pending | raw_req);
	wire next_pend = can_take & ~take & (pending | raw_req);
	// busy stays until done regardless of mode
	always_comb begin
		next_state = state;
		unique case (state)
			dcsc_pkg::DCSC_ST_IDLE: if (take) next_state = dcsc_pkg::DCSC_ST_BUSY;
			dcsc_pkg::DCSC_ST_BUSY: if (xfer_done) next_state = dcsc_pkg::DCSC_ST_IDLE;
		endcase
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state    <= dcsc_pkg::DCSC_ST_IDLE;
			periph_q <= 1'b0;
			pending  <= 1'b0;
			xfer_req <= 1'b0;
		end else if (clk_en) begin
			state    <= next_state;
			periph_q <= periph_req;
			pending  <= next_pend;
			xfer_req <= take;
		end
	end
	assign busy = (state == dcsc_pkg::DCSC_ST_BUSY);
endmodule // dcsc_chan

/* logic/dcsc_top.sv */
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "dcsc_regs.svh"
// four-channel setup registers and request acceptance
module dcsc_top #(
	parameter int NCH = 4,
	parameter int NSRC = 32
) (
	input  wire logic            core_clk,
	input  wire logic            arst_n,
	input  wire logic            clk_en,
	input  wire logic [7:0]      addr,
	input  wire logic [31:0]     wdata,
	input  wire logic            wr_stb,
	input  wire logic            rd_stb,
	output logic      [31:0]     rdata,
	input  wire logic [NSRC-1:0] periph_irq,
	input  wire logic [NCH-1:0]  xfer_done,
	output logic      [NCH-1:0]  xfer_req,
	output logic      [NCH-1:0]  chan_busy,
	output logic      [NCH-1:0]  chan_enabled
);
	logic [7:0]      chan_mode_register [NCH];
	logic [7:0]      request_select_primary [NCH];
	logic [7:0]      request_select_extended [NCH];
	logic [23:0]     param_reg [NCH];
	logic [NSRC-1:0] irq_sync;
	logic [NCH-1:0]  sw_pulse;
	logic [NCH-1:0]  pend;
	logic [NCH-1:0]  done_seen;
	logic [31:0]     next_rdata;

	function automatic logic [7:0] ch_ofs(input int ch, input logic [7:0] base);
		ch_ofs = base + 8'(ch * `DCSC_CH_STRIDE);
	endfunction

	function automatic logic src_pick(input logic [NSRC-1:0] v, input logic [7:0] sel);
		src_pick = v[sel[`DCSC_SEL_LSB +: `DCSC_SEL_W]];
	endfunction

	dcsc_sync #(.W(NSRC)) u_sync (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.clk_en   (clk_en),
		.async_in (periph_irq),
		.sync_out (irq_sync)
	);

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : gch
			wire hit_mode  = wr_stb && addr == ch_ofs(g, `DCSC_OFS_MODE0);
			wire hit_sel   = wr_stb && addr == ch_ofs(g, `DCSC_OFS_SEL0);
			wire hit_sel2  = wr_stb && addr == ch_ofs(g, `DCSC_OFS_SEL20);
			wire hit_param = wr_stb && addr == ch_ofs(g, `DCSC_OFS_PARAM0);
			wire [1:0] md  = chan_mode_register[g][`DCSC_MODE_LSB +: 2];
			// either select field may name the interrupt source
			wire preq = src_pick(irq_sync, request_select_primary[g]) |
			            src_pick(irq_sync, request_select_extended[g]);
			// register writes; software request bit is a pulse, not stored
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					chan_mode_register[g]      <= `DCSC_MODE_RST;
					request_select_primary[g]  <= `DCSC_SEL_RST;
					request_select_extended[g] <= `DCSC_SEL_RST;
					param_reg[g]               <= `DCSC_PARAM_RST;
					sw_pulse[g]                <= 1'b0;
				end else if (clk_en) begin
					if (hit_mode)
						chan_mode_register[g] <= {2'b00, wdata[5:0]};
					if (hit_sel)
						request_select_primary[g] <= {3'b000, wdata[4:0]};
					if (hit_sel2)
						request_select_extended[g] <= {3'b000, wdata[4:0]};
					if (hit_param)
						param_reg[g] <= wdata[23:0];
					sw_pulse[g] <= hit_sel2 & wdata[`DCSC_SWREQ_BIT + 7];
				end
			end
			dcsc_chan u_chan (
				.core_clk   (core_clk),
				.arst_n     (arst_n),
				.clk_en     (clk_en),
				.mode       (md),
				.param_zero (param_reg[g] == 24'h000000),
				.sw_req     (sw_pulse[g]),
				.periph_req (preq),
				.xfer_done  (xfer_done[g]),
				.xfer_req   (xfer_req[g]),
				.busy       (chan_busy[g]),
				.pending    (pend[g])
			);
			assign chan_enabled[g] = md[0]; // single and repeat both have bit 0 set
			// sticky done flag, set wins over clear
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n)
					done_seen[g] <= 1'b0;
				else if (clk_en)
					done_seen[g] <= xfer_done[g] |
					                (done_seen[g] & ~(wr_stb && addr == `DCSC_OFS_DONE && wdata[g]));
			end
		end
	endgenerate

	// read mux
	always_comb begin
		next_rdata = 32'h00000000;
		for (int i = 0; i < NCH; i++) begin
			if (addr == ch_ofs(i, `DCSC_OFS_MODE0))
				next_rdata = {24'h000000, chan_mode_register[i]};
			if (addr == ch_ofs(i, `DCSC_OFS_SEL0))
				next_rdata = {24'h000000, request_select_primary[i]};
			if (addr == ch_ofs(i, `DCSC_OFS_SEL20))
				next_rdata = {24'h000000, request_select_extended[i]};
			if (addr == ch_ofs(i, `DCSC_OFS_PARAM0))
				next_rdata = {8'h00, param_reg[i]};
		end
		if (addr == `DCSC_OFS_STATUS)
			next_rdata = {24'h000000, pend, chan_busy};
		if (addr == `DCSC_OFS_DONE)
			next_rdata = {28'h0000000, done_seen};
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			rdata <= 32'h00000000;
		else if (clk_en)
			rdata <= rd_stb ? next_rdata : 32'h00000000;
	end
endmodule // dcsc_top

/* test/dcsc_chk.sv */
`timescale 1ns/1ps
// port checker for the setup block
module dcsc_chk #(
	parameter int NCH  = 4,
	parameter int NSRC = 32
) (
	input wire logic           core_clk,
	input wire logic           arst_n,
	input wire logic           clk_en,
	input wire logic [7:0]     addr,
	input wire logic [31:0]    wdata,
	input wire logic           wr_stb,
	input wire logic           rd_stb,
	input wire logic [31:0]    rdata,
	input wire logic [NCH-1:0] xfer_done,
	input wire logic [NCH-1:0] xfer_req,
	input wire logic [NCH-1:0] chan_busy,
	input wire logic [NCH-1:0] chan_enabled
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// read data only after a read
	a_rd_idle: assert property (!$past(rd_stb) |-> rdata == 32'h0) else $error("rdata not zero");
	a_rd_unmapped: assert property (rd_stb && addr == 8'h4C |=> rdata == 32'h0) else $error("unmapped read");
	// per channel enable and transfer tracking
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		sequence s_off3;
			!chan_enabled[i] [*3];
		endsequence
		a_mode_write: assert property (wr_stb && clk_en && addr == 8'(i * 16) |=> chan_enabled[i] == $past(wdata[0]))
			else $error("enable off mode");
		a_off_quiet: assert property (s_off3 |=> !xfer_req[i]) else $error("request while off");
		a_busy_cause: assert property ($rose(chan_busy[i]) |-> xfer_req[i]) else $error("busy cause");
		a_busy_keep: assert property (chan_busy[i] && !xfer_done[i] |=> chan_busy[i]) else $error("busy lost");
		a_busy_end: assert property (chan_busy[i] && xfer_done[i] |=> !chan_busy[i]) else $error("busy stuck");
		a_req_pulse: assert property (xfer_req[i] |=> !xfer_req[i]) else $error("request too long");
	end
endmodule // dcsc_chk
bind dcsc_top dcsc_chk #(.NCH(NCH), .NSRC(NSRC)) u_chk (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .addr(addr),
	.wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .xfer_done(xfer_done),
	.xfer_req(xfer_req), .chan_busy(chan_busy), .chan_enabled(chan_enabled));

/* test/dcsc_top_test.sv */
`timescale 1ns/1ps
// bench with a small channel model
module dcsc_top_test;
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        wr_stb = 1'b0;
	logic        rd_stb = 1'b0;
	logic        ce = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] irq = 32'h0;
	logic [3:0]  done = 4'h0;
	logic [31:0] rdata;
	logic [3:0]  req;
	logic [3:0]  busy;
	logic [3:0]  en;
	int          error_cnt = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          mode_m[4];
	int          param_m[4];
	dcsc_top dut (.core_clk(core_clk), .arst_n(arst_n), .clk_en(ce), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .periph_irq(irq), .xfer_done(done),
		.xfer_req(req), .chan_busy(busy), .chan_enabled(en));
	// clock and run ceiling
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 5000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge core_clk);
		wr_stb <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge core_clk);
		rd_stb <= 1'b0;
		#1 chk(rdata, exp);
		@(posedge core_clk);
	endtask
	// disable, program, settle, enable last
	task automatic setup(input int c, input int md, input int pr, input int s);
		wr(8'(c * 16), 32'(mode_m[c] & 'h3C));
		wr(8'(c * 16), 32'(md & 'h3C));
		wr(8'(c * 16 + 12), 32'(pr));
		wr(8'(c * 16 + 4), 32'(s));
		wr(8'(c * 16 + 8), 32'(s));
		repeat (6) @(posedge core_clk);
		wr(8'(c * 16), 32'(md));
		chk({31'h0, en[c]}, 32'(md % 2));
		mode_m[c] = md;
		param_m[c] = pr;
		rd(8'(c * 16), 32'(md));
		rd(8'(c * 16 + 12), 32'(pr));
	endtask
	// raise one request, optionally clear mode mid-transfer
	task automatic go(input int c, input int s, input bit sw, input bit kill);
		int seen;
		int exp;
		seen = 0;
		exp = (mode_m[c] % 2 == 1) && (param_m[c] != 0);
		if (sw) begin
			addr <= 8'(c * 16 + 8);
			wdata <= 32'h80 | 32'(s);
			wr_stb <= 1'b1;
		end else begin
			irq[s] <= 1'b1;
		end
		// watch from the strobe edge on so the one-cycle request is seen
		repeat (10) begin
			@(posedge core_clk);
			wr_stb <= 1'b0;
			#1 seen |= int'(req[c]);
		end
		@(posedge core_clk);
		irq <= 32'h0;
		chk(32'(seen), 32'(exp));
		if (kill) begin
			wr(8'(c * 16), 32'(mode_m[c] & 'h3C));
			mode_m[c] = mode_m[c] & 'h3C;
		end
		chk({31'h0, busy[c]}, 32'(exp));
		rd(8'h40, 32'(exp << c));
		done[c] <= 1'b1;
		@(posedge core_clk);
		done[c] <= 1'b0;
		#1 chk({31'h0, busy[c]}, 32'h0);
		@(posedge core_clk);
		// sticky done flag, then cleared by a one written back
		rd(8'h44, 32'(1 << c));
		wr(8'h44, 32'(1 << c));
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// every mode code on every channel, then param zero
	initial begin
		int s;
		void'($urandom(32'hA79DD939));
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		rd(8'h00, 32'h0);
		// a write while the clock enable is low must not land
		ce <= 1'b0;
		wr(8'h00, 32'h1);
		ce <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h4C, 32'h0);
		for (int c = 0; c < 4; c++) begin
			for (int m = 0; m < 5; m++) begin
				s = $urandom % 32;
				setup(c, int'($urandom & 'h3C) | (m == 4 ? 1 : m), m == 4 ? 0 : int'($urandom % 'hFFFFFF) + 1, s);
				go(c, s, 1'b1, m == 3);
				go(c, s, 1'b0, 1'b0);
			end
		end
		// mid-run reset returns the last channel to its reset values
		arst_n <= 1'b0;
		@(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		rd(8'h30, 32'h0);
		rd(8'h3C, 32'h0);
		tally_and_finish();
	end
endmodule // dcsc_top_test
